/* rtl/aperture_delay_pkg.sv */
// Constants and carriers for the sampling aperture delay control block.
// Assumes one device clock, a simple strobed register port and a
// calibration engine on the same clock.
// Notes on behaviour
// - Completion flag reads 1 only when calibration is enabled and finished.
// - Status returns the 17-bit calibrated delay, valid only while flag is 1.
// - Result bit 16 is inversion, bits 15:8 coarse, bits 7:0 fine.
// - Manual inversion bit set inverts the sampling clock while calibration is off; clear does not.
// - Manual coarse code sets the coarse delay while calibration is off.
// - Manual fine code sets the fine delay while calibration is off.
// - Coarse limit met by small writes or by the automatic ramp.
// - Fine delay accepts any value on a ce edge, applied directly while calibration is off.
// - Ramp moves coarse one code, or four when fast and at least four codes away, every 384 cycles.
// - Without ramp, applied coarse takes the written value within 1536 cycles.
package aperture_delay_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 24;
  localparam int          DELAY_W       = 17;
  localparam int          CODE_W        = 8;

  localparam logic [11:0] ADDR_CAL_STAT = 12'h2b2;
  localparam logic [11:0] ADDR_SETTING  = 12'h2b5;

  localparam int          INV_BIT       = 16;
  localparam int          COARSE_LSB    = 8;
  localparam int          FINE_LSB      = 0;
  localparam int          DONE_BIT      = 17;

  localparam logic [16:0] SETTING_RESET = 17'h00000;
  localparam logic [23:0] RDATA_RESET   = 24'h000000;

  localparam int          RAMP_PERIOD   = 384;
  localparam int          APPLY_LIMIT   = 1536;
  localparam logic [8:0]  RAMP_LAST     = 9'(RAMP_PERIOD - 1);
  localparam logic [7:0]  FAST_STEP     = 8'h04;
  localparam logic [7:0]  SLOW_STEP     = 8'h01;

  typedef struct packed {
    logic       invert;
    logic [7:0] coarse;
    logic [7:0] fine;
  } delay_t;

  typedef struct packed {
    delay_t      setting;
    logic [23:0] rdata;
    logic        rvalid;
    logic        invert;
    logic [7:0]  fine;
    logic        done;
  } top_state_t;

  typedef struct packed {
    logic [7:0] applied;
    logic [8:0] tick;
  } ramp_state_t;

endpackage

/* rtl/coarse_ramp.sv */
// Applied coarse delay tracker with optional slow ramp toward a target.
// Assumes target and mode inputs come from logic on the same clock.
`timescale 1ns/100ps
module coarse_ramp
  import aperture_delay_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       ce_i,
  input  wire logic       ramp_en_i,
  input  wire logic       fast_i,
  input  wire logic [7:0] target_i,
  output logic      [7:0] applied_o
);

  ramp_state_t st;
  ramp_state_t next_st;
  logic [7:0]  gap;
  logic [7:0]  step;

  always_comb begin
    next_st = st;
    gap     = (target_i > st.applied) ? target_i - st.applied
                                      : st.applied - target_i;
    step    = (fast_i && gap >= FAST_STEP) ? FAST_STEP : SLOW_STEP;
    if (!ramp_en_i) begin
      next_st.applied = target_i;
      next_st.tick    = 9'h000;
    end else begin
      // Counter runs free so a retarget never resets the spacing
      next_st.tick = (st.tick == RAMP_LAST) ? 9'h000 : st.tick + 9'h001;
      if (st.tick == RAMP_LAST && gap != 8'h00) begin
        next_st.applied = (target_i > st.applied) ? st.applied + step
                                                  : st.applied - step;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign applied_o = st.applied;

  property p_direct;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !ramp_en_i |=> applied_o == $past(target_i);
  endproperty
  a_direct: assert property (p_direct)
    else $error("coarse not applied directly");

  property p_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && ramp_en_i && st.tick != RAMP_LAST |=> $stable(applied_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("coarse moved between ramp ticks");

  property p_slow_step;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && ramp_en_i && !fast_i && st.tick == RAMP_LAST
      && target_i != applied_o
    |=> (applied_o == $past(applied_o) + 8'h01)
      || (applied_o == $past(applied_o) - 8'h01);
  endproperty
  a_slow_step: assert property (p_slow_step)
    else $error("slow ramp step is not one code");

  property p_fast_step;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && ramp_en_i && fast_i && st.tick == RAMP_LAST
      && target_i > applied_o + 8'h03 && applied_o < 8'hfc
    |=> applied_o == $past(applied_o) + 8'h04;
  endproperty
  a_fast_step: assert property (p_fast_step)
    else $error("fast ramp step is not four codes");

  c_ramp_step: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && ramp_en_i && st.tick == RAMP_LAST && target_i != applied_o);

endmodule

/* rtl/aperture_delay_adjust.sv */
// Aperture delay control: manual setting register, calibration status
// readback and selection of the delay applied to the sampling clock.
// Assumes the register port, calibration engine and ramp controls all
// run on clk_i; none of them is synchronised here.
`timescale 1ns/100ps
module aperture_delay_adjust
  import aperture_delay_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [23:0] reg_wdata_i,
  output logic      [23:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic        sysref_cal_enable_i,
  input  wire logic        cal_finished_i,
  input  wire logic [16:0] cal_delay_result_i,
  input  wire logic        coarse_ramp_enable_i,
  input  wire logic        coarse_ramp_rate_i,
  output logic             cal_complete_flag_o,
  output logic             clock_invert_o,
  output logic      [7:0]  coarse_delay_o,
  output logic      [7:0]  fine_delay_o
);

  top_state_t st;
  top_state_t next_st;
  delay_t     cal_delay;
  logic       cal_active;
  logic [7:0] coarse_target;

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] base);
    hit = (a == base);
  endfunction

  // Result split into inversion, coarse and fine fields
  assign cal_delay     = delay_t'(cal_delay_result_i);
  assign cal_active    = sysref_cal_enable_i & cal_finished_i;
  assign coarse_target = cal_active ? cal_delay.coarse
                                    : st.setting.coarse;

  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    if (reg_wr_i && hit(reg_addr_i, ADDR_SETTING)) begin
      next_st.setting = delay_t'(reg_wdata_i[16:0]);
    end
    if (reg_rd_i) begin
      next_st.rvalid = 1'b1;
      if (hit(reg_addr_i, ADDR_CAL_STAT)) begin
        // Result is returned raw; only meaningful with the done bit
        next_st.rdata = {6'h00, cal_active, cal_delay_result_i};
      end else if (hit(reg_addr_i, ADDR_SETTING)) begin
        next_st.rdata = {7'h00, st.setting};
      end else begin
        next_st.rdata = RDATA_RESET;
      end
    end
    next_st.done = cal_active;
    if (cal_active) begin
      next_st.invert = cal_delay.invert;
      next_st.fine   = cal_delay.fine;
    end else begin
      next_st.invert = st.setting.invert;
      next_st.fine   = st.setting.fine;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // Calibrated coarse value jumps directly; ramp serves manual writes
  coarse_ramp u_coarse_ramp (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .ramp_en_i (coarse_ramp_enable_i & ~cal_active),
    .fast_i    (coarse_ramp_rate_i),
    .target_i  (coarse_target),
    .applied_o (coarse_delay_o)
  );

  assign reg_rdata_o         = st.rdata;
  assign reg_rvalid_o        = st.rvalid;
  assign cal_complete_flag_o = st.done;
  assign clock_invert_o      = st.invert;
  assign fine_delay_o        = st.fine;

  property p_done;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i |=> cal_complete_flag_o ==
             $past(sysref_cal_enable_i && cal_finished_i);
  endproperty
  a_done: assert property (p_done)
    else $error("completion flag does not follow enable and finish");

  property p_status_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && reg_rd_i && reg_addr_i == ADDR_CAL_STAT
    |=> reg_rvalid_o && reg_rdata_o[16:0] == $past(cal_delay_result_i)
        && reg_rdata_o[17] == $past(cal_active)
        && reg_rdata_o[23:18] == 6'h00;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read returned wrong result");

  property p_manual_invert;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !cal_active |=> clock_invert_o == $past(st.setting.invert);
  endproperty
  a_manual_invert: assert property (p_manual_invert)
    else $error("inversion does not follow manual bit");

  property p_manual_fine;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && reg_wr_i && reg_addr_i == ADDR_SETTING && !cal_active
    ##1 ce_i && !cal_active
    |=> fine_delay_o == $past(reg_wdata_i[7:0], 2);
  endproperty
  a_manual_fine: assert property (p_manual_fine)
    else $error("fine code not applied two cycles after write");

  property p_cal_applied;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cal_active
    |=> clock_invert_o == $past(cal_delay_result_i[16])
        && fine_delay_o == $past(cal_delay_result_i[7:0]);
  endproperty
  a_cal_applied: assert property (p_cal_applied)
    else $error("calibrated delay not applied");

  property p_manual_coarse;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !coarse_ramp_enable_i && !cal_active
    |=> coarse_delay_o == $past(st.setting.coarse);
  endproperty
  a_manual_coarse: assert property (p_manual_coarse)
    else $error("manual coarse code not applied");

  // Calibrated coarse bypasses the ramp, or a fresh result would crawl in
  property p_cal_coarse;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && cal_active
    |=> coarse_delay_o == $past(cal_delay_result_i[15:8]);
  endproperty
  a_cal_coarse: assert property (p_cal_coarse)
    else $error("calibrated coarse code not applied");

  property p_setting_write;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && reg_wr_i && reg_addr_i == ADDR_SETTING
    |=> st.setting == $past(reg_wdata_i[16:0]);
  endproperty
  a_setting_write: assert property (p_setting_write)
    else $error("setting write not stored");

  // Status space is read-only; only the setting address moves the setting
  property p_status_ro;
    @(posedge clk_i) disable iff (!reset_n_i)
    !(ce_i && reg_wr_i && reg_addr_i == ADDR_SETTING)
    |=> $stable(st.setting);
  endproperty
  a_status_ro: assert property (p_status_ro)
    else $error("setting changed without a setting write");

  property p_setting_read;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && reg_rd_i && reg_addr_i == ADDR_SETTING
    |=> reg_rdata_o == {7'h00, $past(st.setting)};
  endproperty
  a_setting_read: assert property (p_setting_read)
    else $error("setting readback wrong");

  property p_rvalid;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i
    |=> reg_rvalid_o == $past(reg_rd_i);
  endproperty
  a_rvalid: assert property (p_rvalid)
    else $error("read valid not one cycle after read strobe");

  property p_rdata_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    !(ce_i && reg_rd_i)
    |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_done_off;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !sysref_cal_enable_i
    |=> !cal_complete_flag_o;
  endproperty
  a_done_off: assert property (p_done_off)
    else $error("completion flag set while calibration disabled");

  property p_fine_direct;
    @(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !cal_active
    |=> fine_delay_o == $past(st.setting.fine);
  endproperty
  a_fine_direct: assert property (p_fine_direct)
    else $error("fine code not applied directly");

  c_cal_done: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    !cal_complete_flag_o ##1 cal_complete_flag_o);
  c_status_read: cover property (@(posedge clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == ADDR_CAL_STAT && cal_active);
  c_setting_write: cover property (@(posedge clk_i)
    disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == ADDR_SETTING);

endmodule

/* sim/aperture_delay_adjust_tb.sv */
// Self-checking bench for the aperture delay control block.
// Assumes strobes are taken on a ce edge and read data follows one
// cycle later; the bench drives every port itself.
`timescale 1ns/100ps
module aperture_delay_adjust_tb;
  import aperture_delay_pkg::*;

  logic        clk_i;
  logic        reset_n_i;
  logic        ce_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [11:0] reg_addr_i;
  logic [23:0] reg_wdata_i;
  logic [23:0] reg_rdata_o;
  logic        reg_rvalid_o;
  logic        sysref_cal_enable_i;
  logic        cal_finished_i;
  logic [16:0] cal_delay_result_i;
  logic        coarse_ramp_enable_i;
  logic        coarse_ramp_rate_i;
  logic        cal_complete_flag_o;
  logic        clock_invert_o;
  logic [7:0]  coarse_delay_o;
  logic [7:0]  fine_delay_o;
  int          errors;
  int          n_compared;

  aperture_delay_adjust i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .sysref_cal_enable_i(sysref_cal_enable_i),
    .cal_finished_i(cal_finished_i), .cal_delay_result_i(cal_delay_result_i),
    .coarse_ramp_enable_i(coarse_ramp_enable_i),
    .coarse_ramp_rate_i(coarse_ramp_rate_i),
    .cal_complete_flag_o(cal_complete_flag_o),
    .clock_invert_o(clock_invert_o), .coarse_delay_o(coarse_delay_o),
    .fine_delay_o(fine_delay_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_delay(input logic i, input logic [7:0] c,
                             input logic [7:0] f);
    check_word({7'h0, clock_invert_o, coarse_delay_o, fine_delay_o},
               {7'h0, i, c, f});
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [23:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [11:0] a, input logic [23:0] exp);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check_word({23'h0, reg_rvalid_o}, 24'h000001);
    check_word(reg_rdata_o, exp);
  endtask

  // Level inputs are taken and shown on the same edge; the second edge is margin
  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic ramp_step(input logic [7:0] exp, input int gap);
    logic [7:0] prev;
    int         n;
    prev = coarse_delay_o;
    n = 0;
    while (coarse_delay_o === prev && n < 400) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 400) begin
      errors++;
      print_verdict();
    end else begin
      check_word({16'h0, coarse_delay_o}, {16'h0, exp});
      if (gap > 0) begin
        check_word(24'(n), 24'(gap));
      end
    end
  endtask

  task automatic test_manual();
    check_delay(1'b0, 8'h00, 8'h00);
    reg_read(ADDR_SETTING, 24'h000000);
    reg_write(ADDR_SETTING, 24'hff345a);
    settle();
    check_delay(1'b1, 8'h34, 8'h5a);
    reg_read(ADDR_SETTING, 24'h01345a);
    @(posedge clk_i);
    ce_i <= 1'b0;
    reg_write(ADDR_SETTING, 24'h00ffff);
    @(posedge clk_i);
    ce_i <= 1'b1;
    reg_write(ADDR_CAL_STAT, 24'hffffff);
    reg_read(ADDR_SETTING, 24'h01345a);
    reg_read(12'h2b6, 24'h000000);
    $display("test_manual done");
  endtask

  task automatic test_cal();
    @(posedge clk_i);
    sysref_cal_enable_i <= 1'b1;
    cal_delay_result_i  <= 17'h0a5c3;
    settle();
    check_word({23'h0, cal_complete_flag_o}, 24'h0);
    check_delay(1'b1, 8'h34, 8'h5a);
    @(posedge clk_i);
    cal_finished_i <= 1'b1;
    settle();
    check_word({23'h0, cal_complete_flag_o}, 24'h1);
    check_delay(1'b0, 8'ha5, 8'hc3);
    reg_read(ADDR_CAL_STAT, 24'h02a5c3);
    @(posedge clk_i);
    sysref_cal_enable_i <= 1'b0;
    settle();
    check_word({23'h0, cal_complete_flag_o}, 24'h0);
    check_delay(1'b1, 8'h34, 8'h5a);
    reg_read(ADDR_CAL_STAT, 24'h00a5c3);
    $display("test_cal done");
  endtask

  task automatic test_ramp();
    @(posedge clk_i);
    coarse_ramp_enable_i <= 1'b1;
    // Inversion kept as set while coarse moves on a running clock
    reg_write(ADDR_SETTING, 24'h013611);
    settle();
    check_delay(1'b1, 8'h34, 8'h11);
    ramp_step(8'h35, 0);
    ramp_step(8'h36, 384);
    @(posedge clk_i);
    coarse_ramp_rate_i <= 1'b1;
    reg_write(ADDR_SETTING, 24'h013b11);
    ramp_step(8'h3a, 0);
    ramp_step(8'h3b, 384);
    reg_write(ADDR_SETTING, 24'h013311);
    ramp_step(8'h37, 0);
    ramp_step(8'h33, 384);
    reg_write(ADDR_SETTING, 24'h013211);
    ramp_step(8'h32, 0);
    $display("test_ramp done");
  endtask

  initial begin
    errors = 0;
    n_compared = 0;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 12'h000;
    reg_wdata_i = 24'h000000;
    sysref_cal_enable_i = 1'b0;
    cal_finished_i = 1'b0;
    cal_delay_result_i = 17'h00000;
    coarse_ramp_enable_i = 1'b0;
    coarse_ramp_rate_i = 1'b0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    test_manual();
    test_cal();
    test_ramp();
    print_verdict();
  end
endmodule
